// ==== hw/abs_pkg.sv ====
// Package with constants and types for the accumulator bit-op and data stack datapath
package abs_pkg;
    // ******************************************************************
    // Widths and positions
    // ******************************************************************
    localparam int ACC_W = 32;
    localparam int ENTRY_W = 16;
    localparam int IDX_W = 5;
    localparam int LOGIC_BIT_POS = 7;
    localparam int STACK_DEPTH_DEF = 32;
    localparam logic [31:0] WACC_RST = 32'h0000_0000;
    localparam logic LACC_RST = 1'b0;

    // ******************************************************************
    // Opcodes and operand kinds
    // ******************************************************************
    typedef enum logic [2:0] {
        ABS_OP_NONE,
        ABS_OP_BIT_SET,
        ABS_OP_BIT_CLEAR,
        ABS_OP_BIT_TEST,
        ABS_OP_PUSH,
        ABS_OP_PULL,
        ABS_OP_LOAD
    } abs_op_e;

    typedef enum logic [2:0] {
        ABS_SRC_BIT,
        ABS_SRC_BYTE,
        ABS_SRC_WORD,
        ABS_SRC_DWORD,
        ABS_SRC_CONST
    } abs_src_e;

    typedef enum logic {
        ABS_MODE_WORD,
        ABS_MODE_LOGIC
    } abs_mode_e;
endpackage : abs_pkg

// ==== hw/abs_core.sv ====
// Word/logic accumulators with bit set, clear, test and a LIFO data stack
// Functional notes
// RULE1 - Bit set forces one selected word accumulator bit to 1, others kept.
// RULE2 - Bit clear forces one selected word accumulator bit to 0, others kept.
// RULE3 - Bit index comes from byte, word, doubleword operand content or a constant.
// RULE4 - Index 0 is the LSB, index 31 the MSB.
// RULE5 - Index values are taken modulo 32.
// RULE6 - Bit test loads the logic accumulator with the selected bit.
// RULE7 - After bit test the datapath switches to logic mode.
// RULE8 - Data stack is last-in first-out.
// RULE9 - Logic push takes one 16-bit entry, operand in bit 7.
// RULE10 - Word push always takes two 16-bit entries, one 32-bit value.
// RULE11 - Byte and word operands are sign-extended to 32 bits when pushed.
// RULE12 - Push beyond capacity raises overflow instead of corrupting entries.
// RULE13 - Logic push takes a bit source; word push takes byte/word/dword/constant.
// RULE14 - Logic pull returns bit 7 of top entry; word pull returns two entries.
// RULE15 - Pull from empty stack raises an underflow indication.
// RULE16 - Depth is a parameter; reset empties stack and clears errors.
// RULE17 - An erroring instruction leaves pointer and entries unchanged.
module abs_core #(
    parameter int DEPTH = abs_pkg::STACK_DEPTH_DEF
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // Instruction from sequencer
    input wire logic i_valid,
    input wire abs_pkg::abs_op_e i_op,
    input wire abs_pkg::abs_src_e i_src,
    input wire logic [31:0] i_operand,
    // Accumulators and mode
    output logic [31:0] o_wacc,
    output logic o_lacc,
    output logic o_logic_mode,
    // Pull results
    output logic o_pull_valid,
    output logic o_pull_bit,
    output logic [31:0] o_pull_word,
    // Errors and level
    output logic o_overflow,
    output logic o_underflow,
    output logic [$clog2(DEPTH+1)-1:0] o_level
);
    import abs_pkg::*;

    localparam int PW = $clog2(DEPTH + 1);

    logic [ENTRY_W-1:0] mem [DEPTH];
    logic [31:0] wacc_r;
    logic lacc_r;
    abs_mode_e mode_r;
    logic [PW-1:0] sp_r;
    logic ovf_r;
    logic unf_r;
    logic pv_r;
    logic pbit_r;
    logic [31:0] pword_r;

    // ******************************************************************
    // Decode
    // ******************************************************************
    wire logic [IDX_W-1:0] bit_idx = i_operand[IDX_W-1:0]; // Low five bits give modulo 32 [RULE3] [RULE5]
    wire logic [31:0] bit_mask = 32'h0000_0001 << bit_idx; // Bit 0 is the LSB [RULE4]
    wire logic is_logic_src = (i_src == ABS_SRC_BIT); // [RULE13]
    wire logic [PW-1:0] need = is_logic_src ? PW'(1) : PW'(2); // [RULE9] [RULE10]
    wire logic do_push = i_valid && (i_op == ABS_OP_PUSH);
    wire logic do_pull = i_valid && (i_op == ABS_OP_PULL);
    wire logic push_ovf = do_push && (PW'(DEPTH) - sp_r < need); // [RULE12]
    wire logic pull_unf = do_pull && (sp_r < need); // [RULE15]
    wire logic push_ok = do_push && !push_ovf; // [RULE17]
    wire logic pull_ok = do_pull && !pull_unf; // [RULE17]
    wire logic [31:0] push_val = (i_src == ABS_SRC_BYTE) ? {{24{i_operand[7]}}, i_operand[7:0]} :
                                 (i_src == ABS_SRC_WORD) ? {{16{i_operand[15]}}, i_operand[15:0]} :
                                 i_operand; // [RULE11]
    wire logic [ENTRY_W-1:0] logic_entry = ENTRY_W'(i_operand[0]) << LOGIC_BIT_POS; // [RULE9]
    wire logic [PW-1:0] top1 = sp_r - PW'(1);
    wire logic [PW-1:0] top2 = sp_r - PW'(2);
    wire logic [ENTRY_W-1:0] rd_lo = mem[top1[$clog2(DEPTH)-1:0]];
    wire logic [ENTRY_W-1:0] rd_hi = mem[top2[$clog2(DEPTH)-1:0]];

    // ******************************************************************
    // Accumulators and mode
    // ******************************************************************
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            wacc_r <= WACC_RST;
            lacc_r <= LACC_RST;
            mode_r <= ABS_MODE_WORD;
        end else if (i_valid) begin
            unique case (i_op)
                ABS_OP_BIT_SET: wacc_r <= wacc_r | bit_mask; // [RULE1]
                ABS_OP_BIT_CLEAR: wacc_r <= wacc_r & ~bit_mask; // [RULE2]
                ABS_OP_BIT_TEST: begin
                    lacc_r <= wacc_r[bit_idx]; // [RULE6]
                    mode_r <= ABS_MODE_LOGIC; // [RULE7]
                end
                ABS_OP_LOAD: begin
                    wacc_r <= i_operand;
                    mode_r <= ABS_MODE_WORD;
                end
                ABS_OP_PULL: if (pull_ok && is_logic_src) lacc_r <= rd_lo[LOGIC_BIT_POS]; // [RULE14]
                default: ;
            endcase
        end
    end

    // ******************************************************************
    // Data stack: high half at lower entry address, low half on top
    // ******************************************************************
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sp_r <= '0; // [RULE16]
        end else if (push_ok) begin
            sp_r <= sp_r + need; // [RULE8]
        end else if (pull_ok) begin
            sp_r <= sp_r - need; // [RULE8]
        end
    end

    // Stack storage writes
    always_ff @(posedge i_mclk) begin
        if (push_ok && is_logic_src) begin
            mem[sp_r[$clog2(DEPTH)-1:0]] <= logic_entry; // [RULE9]
        end else if (push_ok) begin
            mem[sp_r[$clog2(DEPTH)-1:0]] <= push_val[31:16]; // [RULE10]
            mem[sp_r[$clog2(DEPTH)-1:0] + 1'b1] <= push_val[15:0];
        end
    end

    // Pull results and error flags
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ovf_r <= 1'b0; // [RULE16]
            unf_r <= 1'b0;
            pv_r <= 1'b0;
            pbit_r <= 1'b0;
            pword_r <= '0;
        end else begin
            ovf_r <= push_ovf; // [RULE12]
            unf_r <= pull_unf; // [RULE15]
            pv_r <= pull_ok;
            if (pull_ok) begin
                pbit_r <= rd_lo[LOGIC_BIT_POS]; // [RULE14]
                pword_r <= is_logic_src ? 32'(rd_lo) : {rd_hi, rd_lo}; // [RULE14]
            end
        end
    end

    // Outputs taken from the registers
    assign o_wacc = wacc_r;
    assign o_lacc = lacc_r;
    assign o_logic_mode = (mode_r == ABS_MODE_LOGIC);
    assign o_pull_valid = pv_r;
    assign o_pull_bit = pbit_r;
    assign o_pull_word = pword_r;
    assign o_overflow = ovf_r;
    assign o_underflow = unf_r;
    assign o_level = sp_r;

    // ******************************************************************
    // Assertions
    // ******************************************************************
    AST_BSET: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE1]
        (i_valid && i_op == ABS_OP_BIT_SET) |=> (o_wacc == ($past(o_wacc) | (32'h1 << $past(i_operand[4:0])))))
        else $error("bit set wrong");
    AST_BCLR: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE2]
        (i_valid && i_op == ABS_OP_BIT_CLEAR) |=> (o_wacc == ($past(o_wacc) & ~(32'h1 << $past(i_operand[4:0])))))
        else $error("bit clear wrong");
    AST_BTEST: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE6]
        (i_valid && i_op == ABS_OP_BIT_TEST) |=> (o_lacc == $past(o_wacc[i_operand[4:0]])))
        else $error("bit test wrong");
    AST_MODE: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE7]
        (i_valid && i_op == ABS_OP_BIT_TEST) |=> o_logic_mode)
        else $error("no logic mode");
    AST_PUSHW: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE10]
        (push_ok && !is_logic_src) |=> (o_level == $past(o_level) + PW'(2)))
        else $error("word push not two entries");
    AST_ROUND: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE8]
        (push_ok && !is_logic_src) ##1 (pull_ok && !is_logic_src && i_op == ABS_OP_PULL)
        |=> (o_pull_word == $past(push_val, 2)))
        else $error("lifo mismatch");
    AST_OVF: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE12]
        push_ovf |=> (o_overflow && $stable(o_level)))
        else $error("overflow wrong");
    AST_UNF: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE15]
        pull_unf |=> (o_underflow && $stable(o_level)))
        else $error("underflow wrong");
    AST_SEXT: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE11]
        (push_ok && i_src == ABS_SRC_BYTE)
        |=> (rd_hi == {16{$past(i_operand[7])}} && rd_lo[15:8] == {8{$past(i_operand[7])}}))
        else $error("sign extension wrong");
    AST_SEXTW: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE11]
        (push_ok && i_src == ABS_SRC_WORD) |=> (rd_hi == {16{$past(i_operand[15])}}))
        else $error("word sign extension wrong");
    AST_PUSHL: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE9]
        (push_ok && is_logic_src)
        |=> (o_level == $past(o_level) + PW'(1) && rd_lo[LOGIC_BIT_POS] == $past(i_operand[0])))
        else $error("logic push wrong");
    AST_PULLW: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE14]
        (pull_ok && !is_logic_src) |=> (o_pull_valid && o_level == $past(o_level) - PW'(2)))
        else $error("word pull wrong");
    AST_PULLL: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE14]
        (pull_ok && is_logic_src) |=> (o_lacc == $past(rd_lo[LOGIC_BIT_POS]) && o_level == $past(o_level) - PW'(1)))
        else $error("logic pull wrong");
    AST_UNFNV: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE17]
        pull_unf |=> (!o_pull_valid && $stable(o_pull_word)))
        else $error("refused pull gave data");
    AST_OVFONLY: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE12]
        !push_ovf |=> !o_overflow)
        else $error("spurious overflow");
    AST_BIDX: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE5]
        (i_valid && i_op == ABS_OP_BIT_SET && i_operand[5]) |=> o_wacc[$past(i_operand[4:0])])
        else $error("bit index not modulo 32");
    AST_LVLMAX: assert property (@(posedge i_mclk) disable iff (!i_rstn) // [RULE12]
        o_level <= PW'(DEPTH))
        else $error("level beyond depth");
    // Cover points for the main scenarios
    COV_PUSH_PULL: cover property (@(posedge i_mclk) disable iff (!i_rstn) push_ok ##1 pull_ok);
    COV_LOGIC_PULL: cover property (@(posedge i_mclk) disable iff (!i_rstn) pull_ok && is_logic_src);
    COV_OVF: cover property (@(posedge i_mclk) disable iff (!i_rstn) push_ovf);
    COV_UNF: cover property (@(posedge i_mclk) disable iff (!i_rstn) pull_unf);
    COV_BT: cover property (@(posedge i_mclk) disable iff (!i_rstn) i_valid && i_op == ABS_OP_BIT_TEST);
endmodule : abs_core

// ==== sim/abs_seq_model.sv ====
// Sequencer model issuing one instruction per clock to the datapath
module abs_seq_model (
    // Clock
    input wire logic i_mclk,
    // Instruction out
    output logic o_valid,
    output abs_pkg::abs_op_e o_op,
    output abs_pkg::abs_src_e o_src,
    output logic [31:0] o_operand
);
    timeunit 1ns;
    timeprecision 1ps;
    import abs_pkg::*;
    // Quiet bus at time zero
    initial begin
        o_valid = 1'b0;
        o_op = ABS_OP_NONE;
        o_src = ABS_SRC_BIT;
        o_operand = 32'h0;
    end
    // Drives one instruction; held until the next call or idle
    task automatic drive(input abs_op_e op, input abs_src_e s, input logic [31:0] x);
        @(negedge i_mclk);
        o_valid = 1'b1;
        o_op = op;
        o_src = s;
        o_operand = x;
    endtask : drive
    task automatic idle();
        @(negedge i_mclk);
        o_valid = 1'b0;
    endtask : idle
endmodule : abs_seq_model

// ==== sim/abs_core_tb.sv ====
// Self-checking bench for the accumulator bit-op and data stack datapath
module abs_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import abs_pkg::*;
    localparam int D = 8;
    localparam int LW = $clog2(D + 1);
    localparam int VW = 70 + LW;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic v, lacc, mode, pv, pb, ovf, udf, tk, l, m, pbx, pk;
    abs_op_e op;
    abs_src_e src;
    logic [31:0] opd, wacc, pw, w, pwx, rv;
    logic [LW-1:0] lvl;
    logic [VW-1:0] q_exp[$], q_msk[$];
    logic [15:0] st [0:D-1];
    int sp, err_total, check_count, cyc, seed = 32'h48a4;
    always #5 i_mclk = ~i_mclk;
    abs_seq_model u_seq (.i_mclk(i_mclk), .o_valid(v), .o_op(op), .o_src(src), .o_operand(opd));
    abs_core #(.DEPTH(D)) u_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_valid(v), .i_op(op), .i_src(src),
        .i_operand(opd), .o_wacc(wacc), .o_lacc(lacc), .o_logic_mode(mode), .o_pull_valid(pv),
        .o_pull_bit(pb), .o_pull_word(pw), .o_overflow(ovf), .o_underflow(udf), .o_level(lvl));
    // Compares each result with the oldest note
    always @(posedge i_mclk) tk <= v;
    always @(negedge i_mclk) begin
        if (tk === 1'b1) begin
            check_count++;
            if ((({wacc, lacc, mode, pv, pb, pw, ovf, udf, lvl} ^ q_exp[0]) & q_msk[0]) !== '0) begin
                err_total++;
                $display("wrong value at %0t: outputs %h", $time, {wacc, lacc, mode, pv, pb, pw, ovf, udf, lvl});
            end
            void'(q_exp.pop_front());
            void'(q_msk.pop_front());
        end
    end
    // Works out the expected outcome, notes it, then issues
    task automatic issue(input abs_op_e o_i, input abs_src_e s, input logic [31:0] x);
        int n;
        logic o, u, p;
        logic [31:0] e;
        n = (s == ABS_SRC_BIT) ? 1 : 2;
        o = 1'b0;
        u = 1'b0;
        p = 1'b0;
        e = (s == ABS_SRC_BYTE) ? {{24{x[7]}}, x[7:0]} : (s == ABS_SRC_WORD) ? {{16{x[15]}}, x[15:0]} : x;
        case (o_i)
            ABS_OP_BIT_SET: w[x[4:0]] = 1'b1;
            ABS_OP_BIT_CLEAR: w[x[4:0]] = 1'b0;
            ABS_OP_BIT_TEST: begin
                l = w[x[4:0]];
                m = 1'b1;
            end
            ABS_OP_LOAD: begin
                w = x;
                m = 1'b0;
            end
            ABS_OP_PUSH: if (sp + n > D) o = 1'b1;
                else begin
                    if (n == 1) st[sp] = {8'h00, x[0], 7'h00};
                    else begin
                        st[sp] = e[31:16];
                        st[sp + 1] = e[15:0];
                    end
                    sp += n;
                end
            ABS_OP_PULL: if (sp < n) u = 1'b1;
                else begin
                    p = 1'b1;
                    pbx = st[sp-1][7];
                    pk = (n == 2);
                    if (n == 1) l = pbx;
                    pwx = (n == 1) ? {16'h0000, st[sp-1]} : {st[sp-2], st[sp-1]};
                    sp -= n;
                end
            default: ;
        endcase
        q_exp.push_back({w, l, m, p, pbx, pwx, o, u, LW'(sp)});
        q_msk.push_back({{36{1'b1}}, (pk ? 32'hFFFF_FFFF : 32'h0000_0080), {(2 + LW){1'b1}}});
        u_seq.drive(o_i, s, x);
    endtask : issue
    // Returns the reference model to its reset state
    task automatic model_clear();
        w = '0;
        pwx = '0;
        l = 1'b0;
        m = 1'b0;
        pbx = 1'b0;
        pk = 1'b1;
        sp = 0;
    endtask : model_clear
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    // Cuts a hang short
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc >= 3000) begin
            err_total++;
            test_done();
        end
    end
    // Main sequence
    initial begin
        model_clear();
        err_total = 0;
        check_count = 0;
        cyc = 0;
        repeat (10) @(negedge i_mclk);
        i_rstn = 1'b1;
        issue(ABS_OP_NONE, ABS_SRC_BIT, 32'h0);
        issue(ABS_OP_PULL, ABS_SRC_BIT, 32'h0);
        issue(ABS_OP_PULL, ABS_SRC_DWORD, 32'h0);
        $display("test reset done");
        issue(ABS_OP_LOAD, ABS_SRC_DWORD, $random(seed));
        for (int i = 0; i < 32; i++) begin
            rv = $random(seed);
            for (int k = 1; k < 5; k++) issue(abs_op_e'(k), abs_src_e'(k), {rv[31:5], 5'(i)});
        end
        $display("test bit ops done");
        for (int k = 0; k < 4; k++) issue(ABS_OP_PULL, ABS_SRC_DWORD, 32'h0);
        issue(ABS_OP_PUSH, ABS_SRC_BYTE, 32'h0000_1280);
        issue(ABS_OP_PUSH, ABS_SRC_WORD, 32'h0001_8001);
        issue(ABS_OP_PUSH, ABS_SRC_BIT, 32'h1);
        issue(ABS_OP_PUSH, ABS_SRC_DWORD, $random(seed));
        issue(ABS_OP_PUSH, ABS_SRC_BIT, 32'h1);
        issue(ABS_OP_PUSH, ABS_SRC_CONST, $random(seed));
        for (int k = 0; k < 6; k++) issue(ABS_OP_PULL, (k == 0 || k == 2) ? ABS_SRC_BIT : ABS_SRC_WORD, 32'h0);
        $display("test stack done");
        for (int k = 0; k < 400; k++) begin
            rv = $random(seed);
            issue(abs_op_e'(rv[15:8] % 7), abs_src_e'(rv[7:0] % 5), $random(seed));
        end
        u_seq.idle();
        repeat (2) @(negedge i_mclk);
        $display("test random done");
        i_rstn = 1'b0;
        repeat (2) @(negedge i_mclk);
        i_rstn = 1'b1;
        model_clear();
        issue(ABS_OP_NONE, ABS_SRC_BIT, 32'h0);
        issue(ABS_OP_PULL, ABS_SRC_DWORD, 32'h0);
        u_seq.idle();
        repeat (2) @(negedge i_mclk);
        $display("test second reset done");
        test_done();
    end
endmodule : abs_core_tb
